// [common/rsq_pkg.sv]
// Constants shared by the reset sequencer device end and the board end.
// Assumes one 50 MHz clock drives both ends.
`default_nettype none
package rsq_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int STRAP_W = 16;
	// Board timing, in ns
	localparam int T_PWRON_LOW_NS = 2000;
	localparam int T_RESET_GAP_NS = 10;
	localparam int T_STRAP_SETUP_NS = 50;
	localparam int T_WARM_LOW_NS = 500;
	// Device timing
	localparam int T_LOCK_MAX_NS = 10000;
	localparam int WDOG_LOCK_REF_CLKS = 24;
	// Cycle counts: least times round up, longest rounds down
	localparam int PWRON_LOW_CYC =
		(T_PWRON_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_GAP_CYC = (T_RESET_GAP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int STRAP_SETUP_CYC = (T_STRAP_SETUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WARM_LOW_CYC = (T_WARM_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int LOCK_MAX_CYC = T_LOCK_MAX_NS / CLK_PERIOD_NS;
	// Device waits this long for lock after release, well under the maximum
	localparam int LOCK_DELAY_CYC = 64;
	localparam int CNT_W = 16;
endpackage
`default_nettype wire

// [common/rsq_if.sv]
// Reset pins between the board end and the device end.
// Assumes both ends share mclk_i; pins are single-direction.
`timescale 1ns/10ps
`default_nettype none
interface rsq_if;
	import rsq_pkg::*;
	logic pwron_rst_n;
	logic reset_in_n;
	logic [STRAP_W-1:0] expansion_address_straps;
	logic lock;
	modport device (input pwron_rst_n, input reset_in_n,
		input expansion_address_straps, output lock);
	modport board (output pwron_rst_n, output reset_in_n,
		output expansion_address_straps, input lock);
endinterface
`default_nettype wire

// [logic/rsq_sync.sv]
// Three-stage synchroniser with second/third agreement.
// Assumes the input is asynchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module rsq_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic async_i,
	output logic level_o
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_level;

	always_comb
	begin
		next_stage = {stage[1:0], async_i};
		next_level = (stage[1] == stage[2]) ? stage[2] : level_o;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			stage <= {3{RESET_VAL}};
			level_o <= RESET_VAL;
		end
		else
		begin
			stage <= next_stage;
			level_o <= next_level;
		end
	end
endmodule // rsq_sync
`default_nettype wire

// [logic/rsq_device.sv]
// Device end: reset entry, strap capture and lock indication.
// Assumes board end keeps the pin timing; watchdog event comes from logic.
`timescale 1ns/10ps
`default_nettype none
module rsq_device
	import rsq_pkg::*;
#(
	parameter int LOCK_CYC = rsq_pkg::LOCK_DELAY_CYC,
	parameter int WDOG_CYC = rsq_pkg::WDOG_LOCK_REF_CLKS
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	rsq_if.device pins,
	input wire logic wdog_event_i,
	input wire logic wdog_rst_end_i,
	output logic boot_start_o,
	output logic core_rst_o,
	output logic mult_rst_o,
	output logic soft_reset_flag_o,
	output logic [rsq_pkg::STRAP_W-1:0] straps_o
);
	import rsq_pkg::*;

	initial
	begin
		if (LOCK_CYC < 1 || LOCK_CYC > LOCK_MAX_CYC || WDOG_CYC < 1)
			$error("rsq_device: bad lock counts");
	end

	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		RSQ_COLD, RSQ_WARM, RSQ_WAIT_LOCK, RSQ_RUN, RSQ_WDOG, RSQ_WDOG_HOLD
	} rsq_state_e;

	logic pwron_n_s;
	logic reset_n_s;
	logic reset_n_d;
	logic [STRAP_W-1:0] strap_s1;
	logic [STRAP_W-1:0] strap_s2;

	rsq_sync #(.RESET_VAL(1'b0)) u_sync_pwron (
		.mclk_i(mclk_i), .srst_i(srst_i),
		.async_i(pins.pwron_rst_n), .level_o(pwron_n_s));
	rsq_sync #(.RESET_VAL(1'b0)) u_sync_reset (
		.mclk_i(mclk_i), .srst_i(srst_i),
		.async_i(pins.reset_in_n), .level_o(reset_n_s));

	////////////////////////////////////////////////////////////////
	rsq_state_e state;
	rsq_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic lock;
	logic next_lock;
	logic boot;
	logic next_boot;
	logic core_rst;
	logic next_core_rst;
	logic mult_rst;
	logic next_mult_rst;
	logic soft_flag;
	logic next_soft_flag;
	logic [STRAP_W-1:0] straps;
	logic [STRAP_W-1:0] next_straps;
	logic rise;

	assign rise = reset_n_s && !reset_n_d;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_lock = lock;
		next_boot = 1'b0;
		next_core_rst = core_rst;
		next_mult_rst = mult_rst;
		next_soft_flag = soft_flag;
		next_straps = straps;
		case (state)
			RSQ_COLD, RSQ_WARM:
			begin
				next_core_rst = 1'b1;
				if (state == RSQ_COLD)
					next_mult_rst = !pwron_n_s;
				if (rise && pwron_n_s)
				begin
					next_straps = strap_s2;
					next_cnt = CNT_W'(LOCK_CYC);
					next_mult_rst = 1'b0;
					next_state = RSQ_WAIT_LOCK;
				end
			end
			RSQ_WAIT_LOCK:
			begin
				if (cnt <= CNT_W'(1))
				begin
					next_lock = 1'b1;
					next_core_rst = 1'b0;
					next_boot = 1'b1;
					next_state = RSQ_RUN;
				end
				else
					next_cnt = cnt - CNT_W'(1);
			end
			RSQ_RUN:
			begin
				if (wdog_event_i)
				begin
					next_lock = 1'b0;
					next_core_rst = 1'b1;
					next_soft_flag = 1'b1;
					next_state = RSQ_WDOG;
				end
			end
			RSQ_WDOG:
			begin
				if (wdog_rst_end_i)
				begin
					next_cnt = CNT_W'(WDOG_CYC);
					next_state = RSQ_WDOG_HOLD;
				end
			end
			RSQ_WDOG_HOLD:
			begin
				if (cnt <= CNT_W'(1))
				begin
					next_lock = 1'b1;
					next_core_rst = 1'b0;
					next_boot = 1'b1;
					next_state = RSQ_RUN;
				end
				else
					next_cnt = cnt - CNT_W'(1);
			end
			default:
				next_state = RSQ_COLD;
		endcase
		// Reset inputs override every state
		if (!pwron_n_s)
		begin
			next_state = RSQ_COLD;
			next_lock = 1'b0;
			next_boot = 1'b0;
			next_core_rst = 1'b1;
			next_mult_rst = 1'b1;
			next_soft_flag = 1'b0;
		end
		else if (!reset_n_s)
		begin
			if (state != RSQ_COLD)
				next_state = RSQ_WARM;
			next_lock = 1'b0;
			next_boot = 1'b0;
			next_core_rst = 1'b1;
			next_soft_flag = 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state <= RSQ_COLD;
			cnt <= '0;
			lock <= 1'b0;
			boot <= 1'b0;
			core_rst <= 1'b1;
			mult_rst <= 1'b1;
			soft_flag <= 1'b0;
			straps <= '0;
			reset_n_d <= 1'b0;
			strap_s1 <= '0;
			strap_s2 <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			lock <= next_lock;
			boot <= next_boot;
			core_rst <= next_core_rst;
			mult_rst <= next_mult_rst;
			soft_flag <= next_soft_flag;
			straps <= next_straps;
			reset_n_d <= reset_n_s;
			strap_s1 <= pins.expansion_address_straps;
			strap_s2 <= strap_s1;
		end
	end

	assign pins.lock = lock;
	assign boot_start_o = boot;
	assign core_rst_o = core_rst;
	assign mult_rst_o = mult_rst;
	assign soft_reset_flag_o = soft_flag;
	assign straps_o = straps;
endmodule // rsq_device
`default_nettype wire

// [logic/rsq_board.sv]
// Board end: drives cold and warm reset sequences and the straps.
// Assumes the device end answers with lock on the shared clock.
`timescale 1ns/10ps
`default_nettype none
module rsq_board
	import rsq_pkg::*;
#(
	parameter int PWRON_CYC = rsq_pkg::PWRON_LOW_CYC
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	rsq_if.board pins,
	input wire logic warm_req_i,
	input wire logic [rsq_pkg::STRAP_W-1:0] strap_val_i,
	output logic busy_o,
	output logic locked_o
);
	import rsq_pkg::*;

	initial
	begin
		if (PWRON_CYC < PWRON_LOW_CYC || PWRON_CYC >= (1 << CNT_W))
			$error("rsq_board: bad power-on count");
	end

	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		RSB_PWRON, RSB_GAP, RSB_WARM, RSB_WAIT, RSB_IDLE
	} rsb_state_e;

	rsb_state_e state;
	rsb_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic pwron_n;
	logic next_pwron_n;
	logic reset_n;
	logic next_reset_n;
	logic [STRAP_W-1:0] straps;
	logic [STRAP_W-1:0] next_straps;
	logic busy;
	logic next_busy;
	logic locked;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_pwron_n = pwron_n;
		next_reset_n = reset_n;
		next_straps = straps;
		next_busy = 1'b1;
		case (state)
			RSB_PWRON:
			begin
				next_pwron_n = 1'b0;
				next_reset_n = 1'b0;
				next_straps = strap_val_i;
				if (cnt >= CNT_W'(PWRON_CYC))
				begin
					next_pwron_n = 1'b1;
					next_cnt = '0;
					next_state = RSB_GAP;
				end
				else
					next_cnt = cnt + CNT_W'(1);
			end
			RSB_GAP:
			begin
				if (cnt >= CNT_W'(RESET_GAP_CYC + STRAP_SETUP_CYC))
				begin
					next_reset_n = 1'b1;
					next_state = RSB_WAIT;
				end
				else
					next_cnt = cnt + CNT_W'(1);
			end
			RSB_WARM:
			begin
				next_pwron_n = 1'b1;
				next_reset_n = 1'b0;
				if (cnt >= CNT_W'(WARM_LOW_CYC))
				begin
					next_reset_n = 1'b1;
					next_state = RSB_WAIT;
				end
				else
					next_cnt = cnt + CNT_W'(1);
			end
			RSB_WAIT:
			begin
				// Straps stay driven until lock is seen
				if (pins.lock)
				begin
					next_busy = 1'b0;
					next_state = RSB_IDLE;
				end
			end
			RSB_IDLE:
			begin
				next_busy = 1'b0;
				if (warm_req_i)
				begin
					next_straps = strap_val_i;
					next_cnt = '0;
					next_reset_n = 1'b0;
					next_busy = 1'b1;
					next_state = RSB_WARM;
				end
			end
			default:
				next_state = RSB_PWRON;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state <= RSB_PWRON;
			cnt <= '0;
			pwron_n <= 1'b0;
			reset_n <= 1'b0;
			straps <= '0;
			busy <= 1'b1;
			locked <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			pwron_n <= next_pwron_n;
			reset_n <= next_reset_n;
			straps <= next_straps;
			busy <= next_busy;
			locked <= pins.lock;
		end
	end

	assign pins.pwron_rst_n = pwron_n;
	assign pins.reset_in_n = reset_n;
	assign pins.expansion_address_straps = straps;
	assign busy_o = busy;
	assign locked_o = locked;
endmodule // rsq_board
`default_nettype wire

// [dv/rsq_props.sv]
// Checker for the reset pins joining the board end and the device end.
// Assumes one clock, synchronous active-high reset, instanced in tb_top.
`timescale 1ns/10ps
`default_nettype none
module rsq_props
	import rsq_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic pwron_rst_n,
	input wire logic reset_in_n,
	input wire logic [STRAP_W-1:0] expansion_address_straps,
	input wire logic lock
);
	import rsq_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// Low-time counters, saturating
	logic [7:0] plow, rlow, next_plow, next_rlow;
	always_comb
	begin
		next_plow = pwron_rst_n ? 8'h00 : plow + 8'(plow != 8'hff);
		next_rlow = reset_in_n ? 8'h00 : rlow + 8'(rlow != 8'hff);
	end
	always_ff @(posedge mclk_i)
	begin
		plow <= srst_i ? 8'h01 : next_plow;
		rlow <= srst_i ? 8'h01 : next_rlow;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_pwron_low_len: assert property (
		$rose(pwron_rst_n) |-> plow >= 8'(PWRON_LOW_CYC))
		else $error("power-on reset released too early");
	a_reset_gap: assert property (
		$rose(pwron_rst_n) |-> !reset_in_n ##1 !reset_in_n)
		else $error("general reset released with no gap");
	a_reset_follow: assert property (
		!pwron_rst_n |-> !reset_in_n)
		else $error("general reset high while power-on low");
	a_lock_time: assert property (
		$rose(reset_in_n) |-> ##[1:500] lock)
		else $error("lock late after release");
	a_strap_setup: assert property (
		$rose(reset_in_n) |->
		expansion_address_straps == $past(expansion_address_straps, 1) &&
		expansion_address_straps == $past(expansion_address_straps, 2) &&
		expansion_address_straps == $past(expansion_address_straps, 3))
		else $error("straps not set up before release");
	a_strap_hold: assert property (
		reset_in_n && !lock |-> $stable(expansion_address_straps))
		else $error("straps moved before lock");
	a_warm_len: assert property (
		$rose(reset_in_n) |-> rlow >= 8'(WARM_LOW_CYC))
		else $error("general reset pulse too short");
	a_warm_pwron: assert property (
		pwron_rst_n && !reset_in_n |=> pwron_rst_n)
		else $error("power-on reset dropped in warm reset");
	a_lock_drop: assert property (
		$fell(reset_in_n) |-> ##[0:5] !lock[*8])
		else $error("lock kept after reset entry");
endmodule // rsq_props
`default_nettype wire

// [dv/tb_top.sv]
// Testbench: cold start, watchdog recovery and warm reset of both ends.
// Assumes rsq_pkg, rsq_if and both design ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rsq_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic warm_req_i = 1'b0;
	logic wdog_event_i = 1'b0;
	logic wdog_rst_end_i = 1'b0;
	logic [STRAP_W-1:0] strap_val_i = 16'ha5c3;
	logic boot_start_o, core_rst_o, mult_rst_o, soft_reset_flag_o;
	logic busy_o, locked_o;
	logic [STRAP_W-1:0] straps_o;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int boots = 0;
	rsq_if pins_if ();
	rsq_device rsq_device_inst (.mclk_i(mclk_i), .srst_i(srst_i),
		.pins(pins_if), .wdog_event_i(wdog_event_i),
		.wdog_rst_end_i(wdog_rst_end_i), .boot_start_o(boot_start_o),
		.core_rst_o(core_rst_o), .mult_rst_o(mult_rst_o),
		.soft_reset_flag_o(soft_reset_flag_o), .straps_o(straps_o));
	rsq_board rsq_board_inst (.mclk_i(mclk_i), .srst_i(srst_i),
		.pins(pins_if), .warm_req_i(warm_req_i),
		.strap_val_i(strap_val_i), .busy_o(busy_o), .locked_o(locked_o));
	rsq_props rsq_props_inst (.mclk_i(mclk_i), .srst_i(srst_i),
		.pwron_rst_n(pins_if.pwron_rst_n), .reset_in_n(pins_if.reset_in_n),
		.expansion_address_straps(pins_if.expansion_address_straps),
		.lock(pins_if.lock));
	always #10 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask
	task automatic wait_for_idle;
		int i;
		i = 0;
		step(4);
		while (busy_o !== 1'b0 && i < 1000)
		begin
			step(1);
			i++;
			if (mult_rst_o !== 1'b0 && i > 200)
				chk("mult_rst_o", 16'h0000, 16'(mult_rst_o));
		end
		chk("busy_o", 16'h0000, 16'(busy_o));
	endtask
	////////////////////////////////////////////////////////////////////////
	// Boot only with lock up; timeout
	always @(posedge mclk_i)
	begin
		cycles++;
		if (boot_start_o === 1'b1)
		begin
			boots++;
			chk("lock at boot", 16'h0001, 16'(pins_if.lock));
		end
		if (cycles > 5000)
		begin
			$display("ERROR cycles expected below %0d seen %0d", 5000, cycles);
			n_fail++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cold_start;
		wait_for_idle();
		chk("lock", 16'h0001, 16'(pins_if.lock));
		chk("straps_o", 16'ha5c3, straps_o);
		chk("boots", 16'h0001, 16'(boots));
		chk("soft_reset_flag_o", 16'h0000, 16'(soft_reset_flag_o));
		chk("mult_rst_o", 16'h0000, 16'(mult_rst_o));
		chk("locked_o", 16'h0001, 16'(locked_o));
		chk("core_rst_o", 16'h0000, 16'(core_rst_o));
	endtask
	task automatic watchdog_reset;
		int n;
		wdog_event_i = 1'b1;
		step(1);
		wdog_event_i = 1'b0;
		chk("lock after event", 16'h0000, 16'(pins_if.lock));
		chk("core_rst_o wdog", 16'h0001, 16'(core_rst_o));
		step(5);
		chk("soft_reset_flag_o", 16'h0001, 16'(soft_reset_flag_o));
		wdog_rst_end_i = 1'b1;
		step(1);
		wdog_rst_end_i = 1'b0;
		n = 0;
		while (pins_if.lock !== 1'b1 && n < 100)
		begin
			step(1);
			n++;
		end
		chk("lock delay near 24", 16'h0001, 16'(n >= WDOG_LOCK_REF_CLKS - 1
			&& n <= WDOG_LOCK_REF_CLKS + 1));
		chk("core_rst_o run", 16'h0000, 16'(core_rst_o));
		chk("straps_o", 16'ha5c3, straps_o);
	endtask
	task automatic warm_reset;
		int i;
		logic core;
		core = 1'b0;
		strap_val_i = 16'h3c5a;
		step(4);
		warm_req_i = 1'b1;
		step(1);
		warm_req_i = 1'b0;
		for (i = 0; i < 1000 && !(i > 8 && busy_o === 1'b0); i++)
		begin
			step(1);
			// Watchdog pulse while waiting for lock must be ignored
			wdog_event_i = (i == 40);
			if (core_rst_o === 1'b1)
				core = 1'b1;
			chk("mult_rst_o", 16'h0000, 16'(mult_rst_o));
		end
		chk("core reset seen", 16'h0001, 16'(core));
		chk("straps_o", 16'h3c5a, straps_o);
		chk("soft_reset_flag_o", 16'h0000, 16'(soft_reset_flag_o));
		chk("lock", 16'h0001, 16'(pins_if.lock));
		chk("boots", 16'h0003, 16'(boots));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		step(16);
		srst_i = 1'b0;
		cold_start();
		watchdog_reset();
		wait_for_idle();
		warm_reset();
		results();
	end
endmodule // tb_top
`default_nettype wire
